// [tsic_irq_ctrl.sv]
// two-source interrupt controller: flags, enables, priority, halt wake
`timescale 1ns/1ns
`default_nettype none
module tsic_irq_ctrl
    import tsic_pkg::*;
(
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic ext_irq_n_in,
    input wire logic timer_overflow_in,
    input wire logic phase_two_clock_in,
    input wire logic [6:0] reg_addr_in,
    input wire logic reg_wr_en_in,
    input wire logic [7:0] reg_wr_data_in,
    output logic [7:0] irq_control_reg_out,
    input wire logic call_push_in,
    input wire logic subroutine_return_op_in,
    input wire logic return_from_isr_op_in,
    input wire logic halt_entry_in,
    output logic irq_ack_out,
    output logic [9:0] irq_vector_out,
    output logic [2:0] stack_level_pointer_out,
    output logic stack_full_out,
    output logic halted_out,
    output logic wake_out,
    output logic wake_resume_next_out
);

    logic ext_level;
    logic ext_fall;
    logic stack_full;
    logic [2:0] stack_level;
    logic global_irq_enable_r;
    logic ext_irq_enable_r;
    logic timer_irq_enable_r;
    logic ext_irq_pending_r;
    logic timer_irq_pending_r;
    logic ext_ready;
    logic timer_ready;
    logic take_irq;
    logic take_ext;
    logic take_timer;
    logic ctrl_wr;
    logic irq_ack_r;
    logic [9:0] irq_vector_r;
    logic ext_at_halt_r;
    logic timer_at_halt_r;
    logic wake_src;
    logic wake_r;
    logic wake_resume_r;
    tsic_pstate_e pstate_r;
    tsic_pstate_e pstate_nxt;

    // ----------------------------------------------------------------
    // sources and stack
    // ----------------------------------------------------------------
    tsic_pin_sync u_pin_sync (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .pin_in(ext_irq_n_in),
        .level_out(ext_level),
        .fall_out(ext_fall)
    );

    // only the program counter goes on the stack at acknowledge
    tsic_stack_level u_stack (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .push_in(call_push_in || irq_ack_r),
        .pop_in(subroutine_return_op_in || return_from_isr_op_in),
        .level_out(stack_level),
        .full_out(stack_full)
    );

    // ----------------------------------------------------------------
    // eligibility and priority
    // ----------------------------------------------------------------
    assign ctrl_wr = reg_wr_en_in && (reg_addr_in == IRQ_CONTROL_ADDR);
    // both enables needed; a full stack blocks
    assign ext_ready = ext_irq_pending_r && ext_irq_enable_r;
    assign timer_ready = timer_irq_pending_r && timer_irq_enable_r;
    // sampled only on a phase-two pulse, never while halted
    assign take_irq = phase_two_clock_in && global_irq_enable_r
        && !stack_full && (ext_ready || timer_ready)
        && (pstate_r == TSIC_RUN);
    assign take_ext = take_irq && ext_ready;
    assign take_timer = take_irq && !ext_ready;

    // ----------------------------------------------------------------
    // enable bits
    // ----------------------------------------------------------------
    // software may set global and source enable inside a handler
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            ext_irq_enable_r <= IRQ_CONTROL_RESET[BIT_EXT_EN];
            timer_irq_enable_r <= IRQ_CONTROL_RESET[BIT_TIMER_EN];
        end else if (ctrl_wr) begin
            ext_irq_enable_r <= reg_wr_data_in[BIT_EXT_EN];
            timer_irq_enable_r <= reg_wr_data_in[BIT_TIMER_EN];
        end
    end

    // acknowledge clear wins over a write or an isr return in that cycle,
    // otherwise a same-cycle write could open a nest the handler never saw
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            global_irq_enable_r <= IRQ_CONTROL_RESET[BIT_GLOBAL_EN];
        end else if (take_irq) begin
            global_irq_enable_r <= 1'b0;
        end else if (return_from_isr_op_in) begin
            global_irq_enable_r <= 1'b1;
        end else if (ctrl_wr) begin
            global_irq_enable_r <= reg_wr_data_in[BIT_GLOBAL_EN];
        end
    end

    // ----------------------------------------------------------------
    // pending flags: hardware set beats software or acknowledge clear
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            ext_irq_pending_r <= IRQ_CONTROL_RESET[BIT_EXT_PEND];
        end else if (ext_fall) begin
            ext_irq_pending_r <= 1'b1;
        end else if (take_ext) begin
            ext_irq_pending_r <= 1'b0;
        end else if (ctrl_wr) begin
            ext_irq_pending_r <= reg_wr_data_in[BIT_EXT_PEND];
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            timer_irq_pending_r <= IRQ_CONTROL_RESET[BIT_TIMER_PEND];
        end else if (timer_overflow_in) begin
            timer_irq_pending_r <= 1'b1;
        end else if (take_timer) begin
            timer_irq_pending_r <= 1'b0;
        end else if (ctrl_wr) begin
            timer_irq_pending_r <= reg_wr_data_in[BIT_TIMER_PEND];
        end
    end

    // unused bits are tied low here, not stored
    assign irq_control_reg_out = {2'b00, timer_irq_pending_r,
        ext_irq_pending_r, 1'b0, timer_irq_enable_r, ext_irq_enable_r,
        global_irq_enable_r};

    // ----------------------------------------------------------------
    // acknowledge and vector
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            irq_ack_r <= 1'b0;
            irq_vector_r <= VEC_RESET;
        end else begin
            irq_ack_r <= take_irq;
            if (take_ext) begin
                irq_vector_r <= VEC_EXT;
            end else if (take_timer) begin
                irq_vector_r <= VEC_TIMER;
            end
        end
    end

    // ----------------------------------------------------------------
    // halt and wake
    // ----------------------------------------------------------------
    // a flag already set at halt entry cannot wake the device
    assign wake_src = (ext_irq_pending_r && !ext_at_halt_r)
        || (timer_irq_pending_r && !timer_at_halt_r);

    always_comb begin
        pstate_nxt = pstate_r;
        case (pstate_r)
            TSIC_RUN: begin
                if (halt_entry_in) begin
                    pstate_nxt = TSIC_HALT;
                end
            end
            TSIC_HALT: begin
                if (wake_src) begin
                    pstate_nxt = TSIC_RUN;
                end
            end
            default: begin
                pstate_nxt = TSIC_RUN;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            pstate_r <= TSIC_RUN;
        end else begin
            pstate_r <= pstate_nxt;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            ext_at_halt_r <= 1'b0;
            timer_at_halt_r <= 1'b0;
        end else if (pstate_r == TSIC_RUN && halt_entry_in) begin
            ext_at_halt_r <= ext_irq_pending_r;
            timer_at_halt_r <= timer_irq_pending_r;
        end
    end

    // resume without vector when nothing woken could be acknowledged
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            wake_r <= 1'b0;
            wake_resume_r <= 1'b0;
        end else begin
            wake_r <= (pstate_r == TSIC_HALT) && wake_src;
            wake_resume_r <= (pstate_r == TSIC_HALT) && wake_src
                && (!global_irq_enable_r || stack_full
                || !(ext_ready || timer_ready));
        end
    end

    assign irq_ack_out = irq_ack_r;
    assign irq_vector_out = irq_vector_r;
    assign stack_level_pointer_out = stack_level;
    assign stack_full_out = stack_full;
    assign halted_out = (pstate_r == TSIC_HALT);
    assign wake_out = wake_r;
    assign wake_resume_next_out = wake_resume_r;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!resetn_in);
    property p_ext_set;
        ext_fall |=> ext_irq_pending_r;
    endproperty
    a_ext_set: assert property (p_ext_set)
        else $error("external edge did not set its pending flag");
    property p_ext_ack;
        (take_ext && !ext_fall) |=> irq_ack_out && irq_vector_out == VEC_EXT
            && !ext_irq_pending_r && !global_irq_enable_r;
    endproperty
    a_ext_ack: assert property (p_ext_ack)
        else $error("external acknowledge vector or clears wrong");
    property p_timer_set;
        timer_overflow_in |=> timer_irq_pending_r;
    endproperty
    a_timer_set: assert property (p_timer_set)
        else $error("timer overflow did not set its pending flag");
    property p_timer_ack;
        (take_timer && !timer_overflow_in) |=> irq_ack_out
            && irq_vector_out == VEC_TIMER && !timer_irq_pending_r
            && !global_irq_enable_r;
    endproperty
    a_timer_ack: assert property (p_timer_ack)
        else $error("timer acknowledge vector or clears wrong");
    property p_full_blocks;
        (phase_two_clock_in && stack_full) |=> !irq_ack_out;
    endproperty
    a_full_blocks: assert property (p_full_blocks)
        else $error("acknowledge taken with a full stack");
    property p_masked;
        (phase_two_clock_in && !global_irq_enable_r) |=> !irq_ack_out;
    endproperty
    a_masked: assert property (p_masked)
        else $error("acknowledge taken with global enable clear");
    property p_return_from_isr_op_sets;
        (return_from_isr_op_in && !take_irq) |=> global_irq_enable_r;
    endproperty
    a_return_from_isr_op_sets: assert property (p_return_from_isr_op_sets)
        else $error("isr return did not set global enable");
    property p_ret_keeps;
        (subroutine_return_op_in && !return_from_isr_op_in && !take_irq
            && !ctrl_wr) |=> $stable(global_irq_enable_r);
    endproperty
    a_ret_keeps: assert property (p_ret_keeps)
        else $error("plain return changed global enable");
    // judged from the visible register, not from the take logic itself
    property p_t2_service;
        (phase_two_clock_in && irq_control_reg_out[BIT_GLOBAL_EN]
            && !stack_full_out && !halted_out
            && ((irq_control_reg_out[BIT_EXT_PEND]
            && irq_control_reg_out[BIT_EXT_EN])
            || (irq_control_reg_out[BIT_TIMER_PEND]
            && irq_control_reg_out[BIT_TIMER_EN]))) |=> irq_ack_out;
    endproperty
    a_t2_service: assert property (p_t2_service)
        else $error("eligible request not taken at phase two");
    property p_priority;
        (take_irq && ext_ready && timer_ready) |=>
            irq_vector_out == VEC_EXT ##1 timer_irq_pending_r;
    endproperty
    a_priority: assert property (p_priority)
        else $error("timer won over a simultaneous external request");
    property p_set_wins;
        (ext_fall && ctrl_wr && !reg_wr_data_in[BIT_EXT_PEND]) |=>
            ext_irq_pending_r;
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("software clear beat a hardware set");
    property p_stale_no_wake;
        (halted_out && timer_at_halt_r && !ext_irq_pending_r) |=> !wake_out;
    endproperty
    a_stale_no_wake: assert property (p_stale_no_wake)
        else $error("flag set before halt woke the device");

    c_nested: cover property (irq_ack_out ##[1:50] irq_ack_out);
    c_full_wait: cover property ((phase_two_clock_in && stack_full
        && ext_ready && global_irq_enable_r) ##[1:50] irq_ack_out);
    c_wake_resume: cover property (wake_out && wake_resume_next_out);
    c_both_pending: cover property (take_irq && ext_ready && timer_ready);

endmodule
`default_nettype wire

// [tsic_pkg.sv]
// constants shared by the two-source interrupt controller files
package tsic_pkg;

    // ----------------------------------------------------------------
    // irq_control_reg location and field layout
    // ----------------------------------------------------------------
    localparam logic [6:0] IRQ_CONTROL_ADDR = 7'h0b;
    localparam logic [7:0] IRQ_CONTROL_RESET = 8'h00;
    localparam int BIT_GLOBAL_EN = 0;
    localparam int BIT_EXT_EN = 1;
    localparam int BIT_TIMER_EN = 2;
    localparam int BIT_EXT_PEND = 4;
    localparam int BIT_TIMER_PEND = 5;

    // ----------------------------------------------------------------
    // vectors and stack
    // ----------------------------------------------------------------
    localparam logic [9:0] VEC_EXT = 10'h004;
    localparam logic [9:0] VEC_TIMER = 10'h008;
    localparam logic [9:0] VEC_RESET = 10'h000;
    localparam logic [2:0] STACK_DEPTH = 3'h4;
    localparam logic [2:0] STACK_LEVEL_RESET = 3'h0;

    // ----------------------------------------------------------------
    // pin synchroniser
    // ----------------------------------------------------------------
    localparam logic [2:0] SYNC_RESET = 3'h7;

    // ----------------------------------------------------------------
    // power state, one-hot
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        TSIC_RUN = 2'h1,
        TSIC_HALT = 2'h2
    } tsic_pstate_e;

endpackage

// [tsic_pin_sync.sv]
// three-stage synchroniser and falling-edge detector for the irq pin
`timescale 1ns/1ns
`default_nettype none
module tsic_pin_sync
    import tsic_pkg::*;
(
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic pin_in,
    output logic level_out,
    output logic fall_out
);

    logic [2:0] sync_r;
    logic level_r;
    logic fall_r;

    // ----------------------------------------------------------------
    // sampling chain; stage 0 only feeds stage 1
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            sync_r <= SYNC_RESET;
        end else begin
            sync_r <= {sync_r[1:0], pin_in};
        end
    end

    // ----------------------------------------------------------------
    // a change counts once stages 1 and 2 agree
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            level_r <= 1'b1;
            fall_r <= 1'b0;
        end else begin
            fall_r <= (sync_r[1] == sync_r[2]) && !sync_r[2] && level_r;
            if (sync_r[1] == sync_r[2]) begin
                level_r <= sync_r[2];
            end
        end
    end

    assign level_out = level_r;
    assign fall_out = fall_r;

endmodule
`default_nettype wire

// [tsic_stack_level.sv]
// return stack level tracker with full flag
`timescale 1ns/1ns
`default_nettype none
module tsic_stack_level
    import tsic_pkg::*;
(
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic push_in,
    input wire logic pop_in,
    output logic [2:0] level_out,
    output logic full_out
);

    logic [2:0] level_r;

    // ----------------------------------------------------------------
    // level count
    // ----------------------------------------------------------------
    // a push when full loses the oldest entry, so the level stays put
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            level_r <= STACK_LEVEL_RESET;
        end else if (push_in && !pop_in && level_r != STACK_DEPTH) begin
            level_r <= level_r + 3'h1;
        end else if (pop_in && !push_in && level_r != 3'h0) begin
            level_r <= level_r - 3'h1;
        end
    end

    assign level_out = level_r;
    assign full_out = (level_r == STACK_DEPTH);

    property p_stack_bound;
        @(posedge clk_in) disable iff (!resetn_in) level_r <= STACK_DEPTH;
    endproperty
    a_stack_bound: assert property (p_stack_bound)
        else $error("stack level beyond four");

endmodule
`default_nettype wire

// [tsic_core_model.sv]
// core-side model: phase-two pulses and the timer overflow source
`timescale 1ns/1ns
`default_nettype none
module tsic_core_model (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic ovf_req_in,
    output logic phase_two_clock_out,
    output logic timer_overflow_out
);
    // ------------------------------------------------------------
    // instruction sequencer
    // ------------------------------------------------------------
    logic [1:0] phase_r;
    // one phase-two pulse per four-clock instruction cycle
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            phase_r <= 2'h0;
        end else begin
            phase_r <= phase_r + 2'h1;
        end
    end
    assign phase_two_clock_out = (phase_r == 2'h3);
    // ------------------------------------------------------------
    // timer overflow
    // ------------------------------------------------------------
    // overflow leaves as ovf_req_in registered one cycle later on the system clock
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            timer_overflow_out <= 1'b0;
        end else begin
            timer_overflow_out <= ovf_req_in;
        end
    end
endmodule
`default_nettype wire

// [two_source_interrupt_controller_test.sv]
// self-checking bench for the two-source interrupt controller
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin \
    num_errors++; \
    $display("CHECK FAILED %s exp %h got %h", nm, exp, got); end end
module two_source_interrupt_controller_test;
    import tsic_pkg::*;
    logic clk_in, resetn_in, pin_n, ovf_req, p2, tov, wr_en;
    logic push, sret, iret, halt, ack, full, halted, wake, wnext;
    logic [6:0] addr;
    logic [7:0] wdata, reg_q;
    logic [9:0] vec;
    logic [2:0] lvl;
    int num_errors = 0;
    int compares = 0;
    logic [6:0] ta [5] = '{7'h0b, 7'h0c, 7'h0b, 7'h0b, 7'h0b};
    logic [7:0] td [5] = '{8'hf8, 8'h07, 8'h06, 8'h01, 8'h00};
    logic [7:0] te [5] = '{8'h30, 8'h30, 8'h06, 8'h01, 8'h00};

    tsic_core_model core (.clk_in(clk_in), .resetn_in(resetn_in),
        .ovf_req_in(ovf_req), .phase_two_clock_out(p2),
        .timer_overflow_out(tov));
    tsic_irq_ctrl dut (.clk_in(clk_in), .resetn_in(resetn_in),
        .ext_irq_n_in(pin_n), .timer_overflow_in(tov),
        .phase_two_clock_in(p2), .reg_addr_in(addr),
        .reg_wr_en_in(wr_en), .reg_wr_data_in(wdata),
        .irq_control_reg_out(reg_q), .call_push_in(push),
        .subroutine_return_op_in(sret), .return_from_isr_op_in(iret),
        .halt_entry_in(halt), .irq_ack_out(ack), .irq_vector_out(vec),
        .stack_level_pointer_out(lvl), .stack_full_out(full),
        .halted_out(halted), .wake_out(wake),
        .wake_resume_next_out(wnext));

    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end

    task automatic end_sim;
        $display("compares %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr_en = 1'b1;
        cyc(1);
        wr_en = 1'b0;
        // let an edge pass so a following write never re-raises the strobe
        cyc(1);
    endtask
    // 0 call, 1 plain return, 2 isr return, 3 halt, 4 timer overflow
    task automatic pulse(input int k);
        case (k)
            0: push = 1'b1;
            1: sret = 1'b1;
            2: iret = 1'b1;
            3: halt = 1'b1;
            default: ovf_req = 1'b1;
        endcase
        cyc(1);
        {push, sret, iret, halt, ovf_req} = 5'h00;
        cyc(1);
    endtask
    // bounded wait on ack (k=0) or wake (k=1); a timeout ends the run
    task automatic wait_hi(input int k);
        int i;
        i = 0;
        while ((k ? wake : ack) !== 1'b1 && i < 30) begin
            cyc(1);
            i++;
        end
        `CHK("handshake", 1'b1, (k ? wake : ack))
        if (i == 30) end_sim();
    endtask
    task automatic no_ack(input int n);
        repeat (n) begin
            cyc(1);
            `CHK("no ack", 1'b0, ack)
        end
    endtask

    initial begin
        {pin_n, ovf_req, wr_en, push, sret, iret, halt} = 7'h40;
        addr = 7'h00;
        wdata = 8'h00;
        resetn_in = 1'b0;
        cyc(12);
        resetn_in = 1'b1;
        cyc(1);
        `CHK("reg reset", IRQ_CONTROL_RESET, reg_q)
        `CHK("vec reset", VEC_RESET, vec)
        `CHK("lvl reset", STACK_LEVEL_RESET, lvl)
        `CHK("halt reset", 1'b0, halted)
        $display("test reset done");
        // ----------------------------------------------------------
        // register rows; the unmapped write must leave the value
        // ----------------------------------------------------------
        for (int r = 0; r < 5; r++) begin
            wr(ta[r], td[r]);
            `CHK("reg row", te[r], reg_q)
        end
        $display("test register rows done");
        wr(7'h0b, 8'h03);
        pin_n = 1'b0;
        wait_hi(0);
        `CHK("ext vec", VEC_EXT, vec)
        `CHK("ext reg", 8'h02, reg_q)
        cyc(1);
        `CHK("ext push", 3'h1, lvl)
        pin_n = 1'b1;
        $display("test external done");
        wr(7'h0b, 8'h06);
        pulse(4);
        cyc(2);
        `CHK("masked flag", 8'h26, reg_q)
        no_ack(8);
        pulse(1);
        `CHK("ret global", 8'h26, reg_q)
        `CHK("ret pop", 3'h0, lvl)
        pulse(0);
        pulse(2);
        wait_hi(0);
        `CHK("tmr vec", VEC_TIMER, vec)
        `CHK("tmr reg", 8'h06, reg_q)
        cyc(1);
        `CHK("tmr lvl", 3'h1, lvl)
        $display("test timer done");
        pin_n = 1'b0;
        pulse(4);
        cyc(4);
        `CHK("both pend", 8'h36, reg_q)
        wr(7'h0b, 8'h37);
        wait_hi(0);
        `CHK("prio vec", VEC_EXT, vec)
        `CHK("prio reg", 8'h26, reg_q)
        pin_n = 1'b1;
        pulse(2);
        wait_hi(0);
        `CHK("second vec", VEC_TIMER, vec)
        cyc(1);
        `CHK("prio lvl", 3'h2, lvl)
        $display("test priority done");
        // two calls from inside the timer handler, with no isr return yet, fill the stack
        pulse(0);
        pulse(0);
        `CHK("full", 1'b1, full)
        `CHK("full lvl", STACK_DEPTH, lvl)
        wr(7'h0b, 8'h13);
        no_ack(10);
        `CHK("held", 8'h13, reg_q)
        pulse(1);
        wait_hi(0);
        `CHK("late vec", VEC_EXT, vec)
        repeat (5) pulse(1);
        `CHK("drained", 3'h0, lvl)
        $display("test stack full done");
        wr(7'h0b, 8'h00);
        pulse(3);
        `CHK("halted", 1'b1, halted)
        pulse(4);
        wait_hi(1);
        `CHK("resume next", 1'b1, wnext)
        `CHK("woke", 1'b0, halted)
        pulse(3);
        pulse(4);
        cyc(6);
        `CHK("no wake", 1'b1, halted)
        pin_n = 1'b0;
        wait_hi(1);
        `CHK("ext resume", 1'b1, wnext)
        pin_n = 1'b1;
        $display("test halt done");
        end_sim();
    end
endmodule
`default_nettype wire
